// file: common/pimu_defines.vh
/*
 * Constants of the integer math unit: register indexes, field positions,
 * opcodes, error codes and reset values.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef PIMU_DEFINES_VH
`define PIMU_DEFINES_VH

// Register indexes on the plain register port
`define PIMU_REG_OPA        4'h0
`define PIMU_REG_OPB        4'h1
`define PIMU_REG_CMD        4'h2
`define PIMU_REG_RESULT     4'h3
`define PIMU_REG_FLAGS      4'h4
`define PIMU_REG_STATUS     4'h5
`define PIMU_REG_IRQ_STAT   4'h6
`define PIMU_REG_IRQ_MASK   4'h7

// Command register fields
`define PIMU_CMD_OP_LSB     0
`define PIMU_CMD_OP_MSB     3
`define PIMU_CMD_PWR_BIT    4
`define PIMU_CMD_CNT_BIT    5
`define PIMU_CMD_IDX_LSB    8
`define PIMU_CMD_IDX_MSB    15

// Flag bits
`define PIMU_FLAG_ZERO      0
`define PIMU_FLAG_CARRY     1
`define PIMU_FLAG_BORROW    2

// Status bits
`define PIMU_STAT_BUSY      0
`define PIMU_STAT_ERR_LSB   8
`define PIMU_STAT_ERR_MSB   10

// Interrupt status bits
`define PIMU_IRQ_DONE       0
`define PIMU_IRQ_ERR        1

// Opcodes
`define PIMU_OP_ADD16       4'h0
`define PIMU_OP_SUB16       4'h1
`define PIMU_OP_MUL16       4'h2
`define PIMU_OP_DIV16       4'h3
`define PIMU_OP_SQRT16      4'h4
`define PIMU_OP_INC16       4'h5
`define PIMU_OP_DEC16       4'h6
`define PIMU_OP_ABS16       4'h7
`define PIMU_OP_NEG16       4'h8
`define PIMU_OP_ADD32       4'h9
`define PIMU_OP_SUB32       4'hA
`define PIMU_OP_MUL32       4'hB

// Error codes
`define PIMU_ERR_NONE       3'h0
`define PIMU_ERR_DIV0       3'h1
`define PIMU_ERR_OPERAND    3'h2
`define PIMU_ERR_COUNTER    3'h3
`define PIMU_ERR_OPCODE     3'h4

// Limits and counts
`define PIMU_MIN16          16'h8000
`define PIMU_MAX_CNT16      8'hC7
`define PIMU_DIV_STEPS      5'h10
`define PIMU_ROOT_STEPS     4'h8

// Reset values
`define PIMU_RST_W32        32'h0000_0000
`define PIMU_RST_MASK       2'h0

`endif

// file: design/pimu_divider.v
/*
 * Signed 16-bit divider, one quotient bit per clock, quotient truncated
 * toward zero and remainder carrying the dividend's sign.
 * Assumes start is a one-cycle pulse given only while idle, divisor nonzero.
 */
`timescale 1ns/1ps
`include "pimu_defines.vh"

module pimu_divider (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        start,
   input  wire [15:0] dividend,
   input  wire [15:0] divisor,
   output wire        done,
   output wire [15:0] quotient,
   output wire [15:0] remainder
);
   reg  [16:0] rem_ff;
   reg  [15:0] quo_ff;
   reg  [15:0] den_ff;
   reg  [4:0]  cnt_ff;
   reg         neg_q_ff;
   reg         neg_r_ff;
   reg         done_ff;
   wire [16:0] shifted;
   wire [16:0] trial;

   assign shifted   = {rem_ff[15:0], quo_ff[15]};
   assign trial     = shifted - {1'b0, den_ff};
   assign done      = done_ff;
   assign quotient  = neg_q_ff ? (16'h0000 - quo_ff) : quo_ff;
   assign remainder = neg_r_ff ? (16'h0000 - rem_ff[15:0]) : rem_ff[15:0];

   always @(posedge clk_sys) begin
      if (rst) begin
         rem_ff   <= 17'h00000;
         quo_ff   <= 16'h0000;
         den_ff   <= 16'h0000;
         cnt_ff   <= 5'h00;
         neg_q_ff <= 1'b0;
         neg_r_ff <= 1'b0;
         done_ff  <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (start) begin
            // Magnitudes; 16'h8000 reads as 32768
            rem_ff   <= 17'h00000;
            quo_ff   <= dividend[15] ? (16'h0000 - dividend) : dividend;
            den_ff   <= divisor[15] ? (16'h0000 - divisor) : divisor;
            neg_q_ff <= dividend[15] ^ divisor[15];
            neg_r_ff <= dividend[15];
            cnt_ff   <= `PIMU_DIV_STEPS;
         end else if (cnt_ff != 5'h00) begin
            if (!trial[16]) begin
               rem_ff <= trial;
               quo_ff <= {quo_ff[14:0], 1'b1};
            end else begin
               rem_ff <= shifted;
               quo_ff <= {quo_ff[14:0], 1'b0};
            end
            cnt_ff <= cnt_ff - 5'h01;
            if (cnt_ff == 5'h01) begin
               done_ff <= 1'b1;
            end
         end
      end
   end
endmodule // pimu_divider

// file: design/pimu_sqrt.v
/*
 * Integer square root of a non-negative 16-bit word, one root bit per clock.
 * Assumes start is a one-cycle pulse given only while idle, operand >= 0.
 */
`timescale 1ns/1ps
`include "pimu_defines.vh"

module pimu_sqrt (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        start,
   input  wire [15:0] radicand,
   output wire        done,
   output wire [7:0]  root,
   output wire        inexact
);
   reg  [15:0] rad_ff;
   reg  [7:0]  root_ff;
   reg  [7:0]  bit_ff;
   reg  [3:0]  cnt_ff;
   reg         done_ff;
   wire [7:0]  cand;
   wire [15:0] cand_sq;
   wire [15:0] root_sq;

   assign cand    = root_ff | bit_ff;
   assign cand_sq = cand * cand;
   assign root_sq = root_ff * root_ff;
   assign done    = done_ff;
   assign root    = root_ff;
   // Fraction discarded when root squared misses
   assign inexact = (root_sq != rad_ff);

   always @(posedge clk_sys) begin
      if (rst) begin
         rad_ff  <= 16'h0000;
         root_ff <= 8'h00;
         bit_ff  <= 8'h00;
         cnt_ff  <= 4'h0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (start) begin
            rad_ff  <= radicand;
            root_ff <= 8'h00;
            bit_ff  <= 8'h80;
            cnt_ff  <= `PIMU_ROOT_STEPS;
         end else if (cnt_ff != 4'h0) begin
            if (cand_sq <= rad_ff) begin
               root_ff <= cand;
            end
            bit_ff <= {1'b0, bit_ff[7:1]};
            cnt_ff <= cnt_ff - 4'h1;
            if (cnt_ff == 4'h1) begin
               done_ff <= 1'b1;
            end
         end
      end
   end
endmodule // pimu_sqrt

// file: design/pimu_top.v
/*
 * Integer math unit: 16-bit and 32-bit controller arithmetic with zero,
 * carry and borrow flags, error reporting and a level interrupt.
 * Assumes a plain-port register master; element memory is written outside
 * from the res_* ports.
 */
// Design decisions made here: strobed register access and the register offsets.
// Contract
// - With power flow valid, a 16x16 signed multiply gives a 32-bit product in two units.
// - A 16-bit divide puts the quotient in the first unit and the remainder in the second.
// - A zero divisor raises a divide-by-zero error and nothing is written.
// - The square root gives the integer root, zero flag on zero root, borrow on a fraction.
// - A negative square root operand raises an operand error and nothing is written.
// - Increment adds one with signed wrap, and on counters only indexes 0 to 199 are allowed.
// - Decrement subtracts one with signed wrap, never saturating.
// - Absolute value writes the magnitude, and the most negative word is an operand error.
// - Negation writes the two's complement, and the most negative word is an operand error.
// - The 32-bit add sums two double words and writes a unit pair.
// - The 32-bit subtract takes the second double word from the first into a unit pair.
// - 32-bit add and subtract set carry above the positive limit and zero on a zero result.
// - 32-bit add and subtract set borrow below the most negative 32-bit value.
// - The 32-bit multiply keeps only the low 32 bits of the product.
// - 16-bit add and subtract set carry above 32767, zero on zero, borrow below -32768.
`timescale 1ns/1ps
`include "pimu_defines.vh"

module pimu_top (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire [3:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output wire [31:0] reg_rdata,
   output wire        res_valid,
   output wire [15:0] res_unit0,
   output wire [15:0] res_unit1,
   output wire        res_two_units,
   output wire        err_pulse,
   output wire [2:0]  err_code,
   output wire        irq
);
   localparam ST_IDLE = 2'h0;
   localparam ST_DIV  = 2'h1;
   localparam ST_ROOT = 2'h2;

   reg  [31:0] opa_ff;
   reg  [31:0] opb_ff;
   reg  [31:0] rdata_ff;
   reg  [1:0]  state_ff;
   reg  [1:0]  nxt_state;
   reg  [2:0]  flags_ff;
   reg  [2:0]  err_code_ff;
   reg         err_pulse_ff;
   reg         res_valid_ff;
   reg  [15:0] res_unit0_ff;
   reg  [15:0] res_unit1_ff;
   reg         res_two_ff;
   reg  [1:0]  irq_stat_ff;
   reg  [1:0]  irq_mask_ff;

   // Outcome of this cycle
   reg         fin;
   reg         fin_err;
   reg  [2:0]  fin_code;
   reg  [31:0] fin_val;
   reg         fin_two;
   reg         fin_flags_upd;
   reg  [2:0]  fin_flags;
   reg         div_start;
   reg         root_start;

   wire        cmd_wr;
   wire [3:0]  cmd_op;
   wire        cmd_pwr;
   wire        cmd_cnt;
   wire [7:0]  cmd_idx;
   wire [15:0] a16;
   wire [15:0] b16;
   wire [16:0] sum17;
   wire [16:0] dif17;
   wire [32:0] sum33;
   wire [32:0] dif33;
   wire [31:0] mul16;
   wire [63:0] mul32;
   wire        div_done;
   wire [15:0] div_quo;
   wire [15:0] div_rem;
   wire        root_done;
   wire [7:0]  root_val;
   wire        root_inexact;
   wire [1:0]  irq_set;

   assign cmd_wr  = reg_wr && (reg_addr == `PIMU_REG_CMD);
   assign cmd_op  = reg_wdata[`PIMU_CMD_OP_MSB:`PIMU_CMD_OP_LSB];
   assign cmd_pwr = reg_wdata[`PIMU_CMD_PWR_BIT];
   assign cmd_cnt = reg_wdata[`PIMU_CMD_CNT_BIT];
   assign cmd_idx = reg_wdata[`PIMU_CMD_IDX_MSB:`PIMU_CMD_IDX_LSB];

   // Low half in the lower unit; all math but the 32-bit multiply is signed
   assign a16   = opa_ff[15:0];
   assign b16   = opb_ff[15:0];
   assign sum17 = {a16[15], a16} + {b16[15], b16};
   assign dif17 = {a16[15], a16} - {b16[15], b16};
   assign sum33 = {opa_ff[31], opa_ff} + {opb_ff[31], opb_ff};
   assign dif33 = {opa_ff[31], opa_ff} - {opb_ff[31], opb_ff};
   assign mul16 = $signed(a16) * $signed(b16);
   // Low word is sign-agnostic
   assign mul32 = opa_ff * opb_ff;

   pimu_divider u_div (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .start     (div_start),
      .dividend  (a16),
      .divisor   (b16),
      .done      (div_done),
      .quotient  (div_quo),
      .remainder (div_rem)
   );

   pimu_sqrt u_root (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .start    (root_start),
      .radicand (a16),
      .done     (root_done),
      .root     (root_val),
      .inexact  (root_inexact)
   );

   // Flags from the unwrapped result, one bit wider
   function [2:0] flags16;
      input [16:0] r;
      begin
         flags16 = 3'h0;
         flags16[`PIMU_FLAG_ZERO]   = (r == 17'h00000);
         flags16[`PIMU_FLAG_CARRY]  = ~r[16] & r[15];
         flags16[`PIMU_FLAG_BORROW] = r[16] & ~r[15];
      end
   endfunction

   function [2:0] flags32;
      input [32:0] r;
      begin
         flags32 = 3'h0;
         flags32[`PIMU_FLAG_ZERO]   = (r == 33'h0_0000_0000);
         flags32[`PIMU_FLAG_CARRY]  = ~r[32] & r[31];
         flags32[`PIMU_FLAG_BORROW] = r[32] & ~r[31];
      end
   endfunction

   always @* begin
      fin           = 1'b0;
      fin_err       = 1'b0;
      fin_code      = `PIMU_ERR_NONE;
      fin_val       = 32'h0000_0000;
      fin_two       = 1'b0;
      fin_flags_upd = 1'b0;
      fin_flags     = 3'h0;
      div_start     = 1'b0;
      root_start    = 1'b0;
      nxt_state     = state_ff;
      case (state_ff)
         ST_IDLE: begin
            // Commands without power flow, or while busy, are ignored
            if (cmd_wr && cmd_pwr) begin
               fin = 1'b1;
               case (cmd_op)
                  `PIMU_OP_ADD16: begin
                     fin_val       = {16'h0000, sum17[15:0]};
                     fin_flags_upd = 1'b1;
                     fin_flags     = flags16(sum17);
                  end
                  `PIMU_OP_SUB16: begin
                     fin_val       = {16'h0000, dif17[15:0]};
                     fin_flags_upd = 1'b1;
                     fin_flags     = flags16(dif17);
                  end
                  `PIMU_OP_MUL16: begin
                     fin_val = mul16;
                     fin_two = 1'b1;
                  end
                  `PIMU_OP_DIV16: begin
                     if (b16 == 16'h0000) begin
                        fin_err  = 1'b1;
                        fin_code = `PIMU_ERR_DIV0;
                     end else begin
                        fin       = 1'b0;
                        div_start = 1'b1;
                        nxt_state = ST_DIV;
                     end
                  end
                  `PIMU_OP_SQRT16: begin
                     if (a16[15]) begin
                        fin_err  = 1'b1;
                        fin_code = `PIMU_ERR_OPERAND;
                     end else begin
                        fin        = 1'b0;
                        root_start = 1'b1;
                        nxt_state  = ST_ROOT;
                     end
                  end
                  `PIMU_OP_INC16: begin
                     if (cmd_cnt && (cmd_idx > `PIMU_MAX_CNT16)) begin
                        fin_err  = 1'b1;
                        fin_code = `PIMU_ERR_COUNTER;
                     end else begin
                        fin_val = {16'h0000, a16 + 16'h0001};
                     end
                  end
                  `PIMU_OP_DEC16: begin
                     fin_val = {16'h0000, a16 - 16'h0001};
                  end
                  `PIMU_OP_ABS16: begin
                     if (a16 == `PIMU_MIN16) begin
                        fin_err  = 1'b1;
                        fin_code = `PIMU_ERR_OPERAND;
                     end else begin
                        fin_val = {16'h0000, a16[15] ? (16'h0000 - a16) : a16};
                        fin_flags_upd = 1'b1;
                        fin_flags[`PIMU_FLAG_ZERO] = (a16 == 16'h0000);
                     end
                  end
                  `PIMU_OP_NEG16: begin
                     if (a16 == `PIMU_MIN16) begin
                        fin_err  = 1'b1;
                        fin_code = `PIMU_ERR_OPERAND;
                     end else begin
                        fin_val = {16'h0000, 16'h0000 - a16};
                        fin_flags_upd = 1'b1;
                        fin_flags[`PIMU_FLAG_ZERO] = (a16 == 16'h0000);
                     end
                  end
                  `PIMU_OP_ADD32: begin
                     fin_val       = sum33[31:0];
                     fin_two       = 1'b1;
                     fin_flags_upd = 1'b1;
                     fin_flags     = flags32(sum33);
                  end
                  `PIMU_OP_SUB32: begin
                     fin_val       = dif33[31:0];
                     fin_two       = 1'b1;
                     fin_flags_upd = 1'b1;
                     fin_flags     = flags32(dif33);
                  end
                  `PIMU_OP_MUL32: begin
                     fin_val = mul32[31:0];
                     fin_two = 1'b1;
                  end
                  default: begin
                     fin_err  = 1'b1;
                     fin_code = `PIMU_ERR_OPCODE;
                  end
               endcase
            end
         end
         ST_DIV: begin
            if (div_done) begin
               fin       = 1'b1;
               fin_val   = {div_rem, div_quo};
               fin_two   = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         ST_ROOT: begin
            if (root_done) begin
               fin           = 1'b1;
               fin_val       = {24'h00_0000, root_val};
               fin_flags_upd = 1'b1;
               fin_flags[`PIMU_FLAG_ZERO]   = (root_val == 8'h00);
               fin_flags[`PIMU_FLAG_BORROW] = root_inexact;
               nxt_state     = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   assign irq_set = {fin && fin_err, fin && !fin_err};

   always @(posedge clk_sys) begin
      if (rst) begin
         opa_ff       <= `PIMU_RST_W32;
         opb_ff       <= `PIMU_RST_W32;
         state_ff     <= ST_IDLE;
         flags_ff     <= 3'h0;
         err_code_ff  <= `PIMU_ERR_NONE;
         err_pulse_ff <= 1'b0;
         res_valid_ff <= 1'b0;
         res_unit0_ff <= 16'h0000;
         res_unit1_ff <= 16'h0000;
         res_two_ff   <= 1'b0;
         irq_mask_ff  <= `PIMU_RST_MASK;
      end else begin
         state_ff     <= nxt_state;
         err_pulse_ff <= fin && fin_err;
         res_valid_ff <= fin && !fin_err;
         if (reg_wr && (reg_addr == `PIMU_REG_OPA)) begin
            opa_ff <= reg_wdata;
         end
         if (reg_wr && (reg_addr == `PIMU_REG_OPB)) begin
            opb_ff <= reg_wdata;
         end
         if (reg_wr && (reg_addr == `PIMU_REG_IRQ_MASK)) begin
            irq_mask_ff <= reg_wdata[1:0];
         end
         if (fin && fin_err) begin
            // Rejected: results and flags hold
            err_code_ff <= fin_code;
         end else if (fin) begin
            err_code_ff  <= `PIMU_ERR_NONE;
            res_unit0_ff <= fin_val[15:0];
            res_unit1_ff <= fin_val[31:16];
            res_two_ff   <= fin_two;
            if (fin_flags_upd) begin
               flags_ff <= fin_flags;
            end
         end
      end
   end

   // Read clears sticky bits; a same-cycle event wins
   always @(posedge clk_sys) begin
      if (rst) begin
         irq_stat_ff <= 2'h0;
      end else if (reg_rd && (reg_addr == `PIMU_REG_IRQ_STAT)) begin
         irq_stat_ff <= irq_set;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_set;
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `PIMU_REG_OPA:      rdata_ff <= opa_ff;
            `PIMU_REG_OPB:      rdata_ff <= opb_ff;
            `PIMU_REG_RESULT:   rdata_ff <= {res_unit1_ff, res_unit0_ff};
            `PIMU_REG_FLAGS:    rdata_ff <= {29'h0000_0000, flags_ff};
            `PIMU_REG_STATUS:   rdata_ff <= {21'h00_0000, err_code_ff, 7'h00,
                                             state_ff != ST_IDLE};
            `PIMU_REG_IRQ_STAT: rdata_ff <= {30'h0000_0000, irq_stat_ff};
            `PIMU_REG_IRQ_MASK: rdata_ff <= {30'h0000_0000, irq_mask_ff};
            default:            rdata_ff <= 32'h0000_0000;
         endcase
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   assign reg_rdata     = rdata_ff;
   assign res_valid     = res_valid_ff;
   assign res_unit0     = res_unit0_ff;
   assign res_unit1     = res_unit1_ff;
   assign res_two_units = res_two_ff;
   assign err_pulse     = err_pulse_ff;
   assign err_code      = err_code_ff;
   assign irq           = |(irq_stat_ff & irq_mask_ff);
endmodule // pimu_top

// file: dv/pimu_monitor.sv
/* Port checker for pimu_top, bound below.
   Assumes the codes of pimu_defines.vh. */
`timescale 1ns/1ps
module pimu_monitor (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire [3:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [31:0] reg_rdata,
   input  wire        res_valid,
   input  wire [15:0] res_unit0,
   input  wire [15:0] res_unit1,
   input  wire        res_two_units,
   input  wire        err_pulse,
   input  wire [2:0]  err_code,
   input  wire        irq
);
   reg  [31:0] opa_ff;
   reg  [31:0] opb_ff;
   reg         busy_ff;
   wire [3:0]  op      = reg_wdata[3:0];
   wire        go      = reg_wr && reg_addr == 4'h2 && reg_wdata[4] && !busy_ff;
   wire        a_neg   = opa_ff[15];
   wire        b_zero  = opb_ff[15:0] == 16'h0000;
   wire [31:0] mul_exp = $signed(opa_ff[15:0]) * $signed(opb_ff[15:0]);
   // Shadow operands, so results tie to what was written
   always @(posedge clk_sys) begin
      if (rst) begin
         opa_ff <= 32'h0;
         opb_ff <= 32'h0;
         busy_ff <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == 4'h0) opa_ff <= reg_wdata;
         if (reg_wr && reg_addr == 4'h1) opb_ff <= reg_wdata;
         if (go && ((op == 4'h3 && !b_zero) || (op == 4'h4 && !a_neg))) busy_ff <= 1'b1;
         else if (res_valid || err_pulse) busy_ff <= 1'b0;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   one_pulse_a: assert property (!(res_valid && err_pulse))
      else $error("both pulses");
   err_hold_a: assert property (err_pulse |-> $stable({res_unit1, res_unit0}))
      else $error("units moved on reject");
   ok_code_a: assert property (res_valid |-> err_code == 3'h0)
      else $error("code left on success");
   mul_pair_a: assert property (go && op == 4'h2 |=> res_valid && res_two_units
      && {res_unit1, res_unit0} == $past(mul_exp)) else $error("bad 16-bit product");
   add_word_a: assert property (go && op == 4'h0 |=> res_valid
      && res_unit0 == $past(opa_ff[15:0] + opb_ff[15:0])) else $error("bad 16-bit sum");
   div_zero_a: assert property (go && op == 4'h3 && b_zero |=> err_pulse && err_code == 3'h1)
      else $error("zero divisor taken");
   div_time_a: assert property (go && op == 4'h3 && !b_zero |-> ##18 res_valid && res_two_units)
      else $error("divide result late");
   root_time_a: assert property (go && op == 4'h4 && !a_neg |-> ##1 !res_valid [*8] ##2 res_valid)
      else $error("root result off time");
   root_neg_a: assert property (go && op == 4'h4 && a_neg |=> err_pulse && err_code == 3'h2)
      else $error("negative root taken");
   min_word_a: assert property (go && (op == 4'h7 || op == 4'h8)
      && opa_ff[15:0] == 16'h8000 |=> err_pulse && err_code == 3'h2) else $error("min word taken");
   cnt_range_a: assert property (go && op == 4'h5 && reg_wdata[5] && reg_wdata[15:8] > 8'hC7
      |=> err_pulse && err_code == 3'h3) else $error("counter index taken");
   cover property (go && op == 4'h3 && !b_zero);
   cover property (err_pulse && err_code == 3'h3);
   cover property (irq);
endmodule // pimu_monitor

bind pimu_top pimu_monitor u_pimu_monitor (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .res_valid(res_valid), .res_unit0(res_unit0), .res_unit1(res_unit1),
   .res_two_units(res_two_units), .err_pulse(err_pulse), .err_code(err_code), .irq(irq));

// file: dv/tb_top.sv
/* Self-checking bench for pimu_top on its register port.
   Assumes the map and codes of the design header. */
`timescale 1ns/1ps
module tb_top;
   reg         clk_sys   = 1'b0;
   reg         rst       = 1'b1;
   reg  [3:0]  reg_addr  = 4'h0;
   reg  [31:0] reg_wdata = 32'h0;
   reg         reg_wr    = 1'b0;
   reg         reg_rd    = 1'b0;
   wire [31:0] reg_rdata;
   wire        res_valid, res_two_units, err_pulse, irq;
   wire [15:0] res_unit0, res_unit1;
   wire [2:0]  err_code;
   reg  [31:0] rd_val;
   integer     fails     = 0;
   integer     cmp_count = 0;
   integer     i;
   always #10 clk_sys = ~clk_sys;
   pimu_top u_pimu_top (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .res_valid(res_valid), .res_unit0(res_unit0), .res_unit1(res_unit1),
      .res_two_units(res_two_units), .err_pulse(err_pulse), .err_code(err_code), .irq(irq));
   task chk(input string name, input [31:0] exp, input [31:0] got);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // Data stand one cycle after the strobe
   task rd(input [3:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask
   task wt;
      integer n;
      n = 0;
      #1;
      while (res_valid !== 1'b1 && err_pulse !== 1'b1 && n < 40) begin
         @(posedge clk_sys);
         #1;
         n = n + 1;
      end
      if (n == 40) chk("completion", 32'h1, 32'h0);
   endtask
   task quiet;
      repeat (3) begin
         #1;
         chk("no pulse", 32'h0, {31'h0, res_valid | err_pulse});
         @(posedge clk_sys);
      end
   endtask
   // On a reject exp is the unit0 left before
   task run(input [3:0] op, input [31:0] a, input [31:0] b, input [8:0] cx,
            input [31:0] exp, input [2:0] ec, input [2:0] fl);
      reg two;
      two = ec == 3'h0 && (op == 4'h2 || op == 4'h3 || op > 4'h8);
      wr(4'h0, a);
      wr(4'h1, b);
      wr(4'h2, {16'h0, cx[8:1], 2'b00, cx[0], 1'b1, op});
      wt;
      chk("error code", {29'h0, ec}, {29'h0, err_code});
      chk("error pulse", {31'h0, ec != 3'h0}, {31'h0, err_pulse});
      chk("result", exp, two ? {res_unit1, res_unit0} : {16'h0, res_unit0});
      rd(4'h4);
      chk("flags", {29'h0, fl}, rd_val);
   endtask
   task t_reset;
      chk("irq", 32'h0, {31'h0, irq});
      rd(4'h7);
      chk("mask", 32'h0, rd_val);
      rd(4'h3);
      chk("result reg", 32'h0, rd_val);
      rd(4'hF);
      chk("unmapped", 32'h0, rd_val);
      wr(4'h4, 32'h0000_FFFF);
      rd(4'h4);
      chk("read only", 32'h0, rd_val);
   endtask
   task t_word;
      run(4'h0, 32'h7FFF, 32'h1, 9'h0, 32'h8000, 3'h0, 3'h2);
      run(4'h1, 32'h8000, 32'h1, 9'h0, 32'h7FFF, 3'h0, 3'h4);
      run(4'h0, 32'h5, 32'hFFFB, 9'h0, 32'h0, 3'h0, 3'h1);
      run(4'h2, 32'hFFFE, 32'h3, 9'h0, 32'hFFFF_FFFA, 3'h0, 3'h1);
      run(4'h2, 32'h03E8, 32'h07D0, 9'h0, 32'h001E_8480, 3'h0, 3'h1);
      run(4'h3, 32'h09C4, 32'h03E8, 9'h0, 32'h01F4_0002, 3'h0, 3'h1);
      run(4'h3, 32'hFFF9, 32'h2, 9'h0, 32'hFFFF_FFFD, 3'h0, 3'h1);
      run(4'h3, 32'h5, 32'h0, 9'h0, 32'hFFFD, 3'h1, 3'h1);
   endtask
   task t_root;
      run(4'h4, 32'h03E8, 32'h0, 9'h0, 32'h1F, 3'h0, 3'h4);
      run(4'h4, 32'h0, 32'h0, 9'h0, 32'h0, 3'h0, 3'h1);
      run(4'h4, 32'h10, 32'h0, 9'h0, 32'h4, 3'h0, 3'h0);
      run(4'h4, 32'hFFFF, 32'h0, 9'h0, 32'h4, 3'h2, 3'h0);
   endtask
   task t_step;
      run(4'h5, 32'h7FFF, 32'h0, 9'h0, 32'h8000, 3'h0, 3'h0);
      run(4'h5, 32'h5, 32'h0, {8'hC7, 1'b1}, 32'h6, 3'h0, 3'h0);
      run(4'h5, 32'h5, 32'h0, {8'hC8, 1'b1}, 32'h6, 3'h3, 3'h0);
      run(4'h6, 32'h8000, 32'h0, 9'h0, 32'h7FFF, 3'h0, 3'h0);
   endtask
   task t_sign;
      run(4'h7, 32'hFC18, 32'h0, 9'h0, 32'h03E8, 3'h0, 3'h0);
      run(4'h8, 32'h03E8, 32'h0, 9'h0, 32'hFC18, 3'h0, 3'h0);
      run(4'h8, 32'h0, 32'h0, 9'h0, 32'h0, 3'h0, 3'h1);
      run(4'h7, 32'h8000, 32'h0, 9'h0, 32'h0, 3'h2, 3'h1);
      run(4'h8, 32'h8000, 32'h0, 9'h0, 32'h0, 3'h2, 3'h1);
   endtask
   task t_dword;
      run(4'h9, 32'h186A0, 32'h30D40, 9'h0, 32'h493E0, 3'h0, 3'h0);
      run(4'h9, 32'h7FFF_FFFF, 32'h1, 9'h0, 32'h8000_0000, 3'h0, 3'h2);
      run(4'hA, 32'h8000_0000, 32'h1, 9'h0, 32'h7FFF_FFFF, 3'h0, 3'h4);
      run(4'hA, 32'h5, 32'h5, 9'h0, 32'h0, 3'h0, 3'h1);
      run(4'hB, 32'h14438, 32'h07D0, 9'h0, 32'h09E4_F580, 3'h0, 3'h1);
      run(4'hB, 32'h10000, 32'h10000, 9'h0, 32'h0, 3'h0, 3'h1);
   endtask
   task t_refuse;
      for (i = 12; i < 16; i = i + 1)
         run(i[3:0], 32'h1, 32'h1, 9'h0, 32'h0, 3'h4, 3'h1);
      wr(4'h2, 32'h0);
      quiet;
      wr(4'h0, 32'h64);
      wr(4'h1, 32'h3);
      wr(4'h2, 32'h13);
      wr(4'h2, 32'h10);
      wt;
      chk("busy divide", 32'h0001_0021, {res_unit1, res_unit0});
      @(posedge clk_sys);
      quiet;
   endtask
   task t_irq;
      rd(4'h6);
      wr(4'h7, 32'h1);
      run(4'h0, 32'h1, 32'h1, 9'h0, 32'h2, 3'h0, 3'h0);
      chk("irq done", 32'h1, {31'h0, irq});
      rd(4'h6);
      chk("irq stat", 32'h1, rd_val);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(4'h7, 32'h2);
      run(4'h4, 32'h8001, 32'h0, 9'h0, 32'h2, 3'h2, 3'h0);
      chk("irq error", 32'h1, {31'h0, irq});
      rd(4'h6);
      chk("irq stat", 32'h2, rd_val);
      wr(4'h7, 32'h0);
      run(4'h0, 32'h2, 32'h1, 9'h0, 32'h3, 3'h0, 3'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #400000;
      fails = fails + 1;
      results;
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      t_word;
      t_root;
      t_step;
      t_sign;
      t_dword;
      t_refuse;
      t_irq;
      results;
   end
endmodule // tb_top
